/* hw/sdm_switch_monitor.sv */
// switch monitor: open-load, link watchdog, indicators, register port
`timescale 1ns/1ps

// Notes on behaviour
// - open-load warning only while channel commanded off
// - measure load off only; flag clear when on
// - off and load open sets bit, pin
// - open-load pin active-low open-drain, optional
// - enable bit zero drives first channel
// - watchdog and errors set link fault flag
// - link fault disables all outputs at once
// - outputs stay off until fault gone, cleared
// - switch side supply lost sets link fault
// - logic side supply lost disables all outputs
// - on/off commands on dedicated one-way outputs
// - indicator pins mirror actual switch state
// - over-current clears state bit, indicator off
// - recovery turns indicator on immediately
// - host reads status, clears reports, configures
// - up to thirty-two chained devices, addressed
// - link fault in bit 7, address 0
// - open warnings bits 0 and 4, address 1
module sdm_switch_monitor
  import sdm_pkg::*;
#(
  parameter int unsigned NUM_CH       = sdm_pkg::SDM_MAXCH,
  parameter int unsigned WDOG_CYC     = sdm_pkg::SDM_WDOG_CYC_DEF,
  parameter bit          HAS_OPEN_PIN = 1'b1,
  parameter bit          HAS_LED_PIN  = 1'b1
) (
  input  wire logic                         clock_i,
  input  wire logic                         rstn_i,
  input  wire logic [sdm_pkg::SDM_AW-1:0]   addr_i,
  input  wire logic [sdm_pkg::SDM_DW-1:0]   wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [sdm_pkg::SDM_DW-1:0]   rdata_o,
  input  wire logic [sdm_pkg::SDM_CHW-1:0]  chain_pos_i,
  input  wire logic [NUM_CH-1:0]            channel_input_i,
  input  wire logic [NUM_CH-1:0]            load_open_i,
  input  wire logic [NUM_CH-1:0]            over_current_i,
  input  wire logic                         link_beat_i,
  input  wire logic                         link_err_i,
  input  wire logic                         switch_side_supply_i,
  input  wire logic                         logic_side_supply_i,
  output logic      [NUM_CH-1:0]            switch_drive_o,
  output logic      [NUM_CH-1:0]            state_indicator_pin_o,
  output logic      [NUM_CH-1:0]            state_indicator_pin_oe_o,
  output logic                              open_load_pin_o,
  output logic                              open_load_pin_oe_o,
  output logic                              irq_o
);
  import sdm_pkg::*;

  localparam int unsigned WDW = (WDOG_CYC > 1) ? $clog2(WDOG_CYC) : 1;
  localparam int unsigned SW  = 3 * NUM_CH + 4 + SDM_CHW;
  localparam logic [WDW-1:0] WD_LAST = WDW'(WDOG_CYC - 1);

  initial begin
    if (NUM_CH < 1 || NUM_CH > SDM_MAXCH || WDOG_CYC < 2) begin
      $error("sdm_switch_monitor: unsupported parameters");
    end
  end

  typedef struct packed {
    logic [SW-1:0]     s1;
    logic [SW-1:0]     s2;
    logic              beat_d;
    logic [WDW-1:0]    wd;
    logic              link_fault;
    logic [NUM_CH-1:0] switch_enable_bits;
    logic [NUM_CH-1:0] drive;
    logic [NUM_CH-1:0] open_warn;
    logic [NUM_CH-1:0] oc_rep;
    logic [SDM_EVW-1:0] ev;
    logic [SDM_EVW-1:0] mask;
    logic [SDM_DW-1:0] rdata;
  } sdm_state_s;

  // supplies read as present until the synchroniser fills
  localparam logic [SW-1:0] SYNC_RST = {{SDM_CHW{1'b0}}, 2'b11, {(2 + 3 * NUM_CH){1'b0}}};
  localparam sdm_state_s    S_RST    = '{s1: SYNC_RST, s2: SYNC_RST, default: '0};

  sdm_state_s s;
  sdm_state_s next_s;

  // synchronised pin inputs
  logic [NUM_CH-1:0]  chin;
  logic [NUM_CH-1:0]  lo;
  logic [NUM_CH-1:0]  ocq;
  logic               beat;
  logic               err;
  logic               sw_ok;
  logic               lg_ok;
  logic [SDM_CHW-1:0] chain;

  assign {chain, lg_ok, sw_ok, err, beat, ocq, lo, chin} = s.s2;

  logic [NUM_CH-1:0] cmd;
  logic              wd_exp;
  logic              link_bad;
  logic              sel;
  logic              wr_hit;
  logic              rd_hit;
  logic [SDM_RW-1:0] ridx;
  logic              clr_link;
  logic [3:0]        ow4;
  logic [3:0]        oc4;
  logic [3:0]        st4;
  logic [3:0]        en4;
  logic [SDM_DW-1:0] mux;
  logic [SDM_EVW-1:0] ev_in;

  always_comb begin
    ow4 = '0;
    oc4 = '0;
    st4 = '0;
    en4 = '0;
    ow4[NUM_CH-1:0] = s.open_warn;
    oc4[NUM_CH-1:0] = s.oc_rep;
    st4[NUM_CH-1:0] = s.drive;
    en4[NUM_CH-1:0] = s.switch_enable_bits;
  end

  // register port and chain address decode
  assign ridx   = addr_i[SDM_RW-1:0];
  assign sel    = (addr_i[SDM_AW-1:SDM_AW-SDM_CHW] == chain);
  assign wr_hit = wr_i & sel;
  assign rd_hit = rd_i & sel;

  always_comb begin
    mux = SDM_REG_RST;
    case (ridx)
      SDM_TOP_REG_OFF: begin
        mux[SDM_LINK_BIT] = s.link_fault;
        mux[3:0] = ow4 | oc4;
      end
      SDM_CHAN_A_OFF: begin
        mux[SDM_OW_BIT] = ow4[0];
        mux[SDM_OC_BIT] = oc4[0];
        mux[SDM_OW_BIT + SDM_CH_STRIDE] = ow4[1];
        mux[SDM_OC_BIT + SDM_CH_STRIDE] = oc4[1];
      end
      SDM_CHAN_B_OFF: begin
        mux[SDM_OW_BIT] = ow4[2];
        mux[SDM_OC_BIT] = oc4[2];
        mux[SDM_OW_BIT + SDM_CH_STRIDE] = ow4[3];
        mux[SDM_OC_BIT + SDM_CH_STRIDE] = oc4[3];
      end
      SDM_STATE_OFF: begin
        mux = {st4, en4};
      end
      SDM_IRQ_STS_OFF: begin
        mux[SDM_EVW-1:0] = s.ev;
      end
      SDM_IRQ_MASK_OFF: begin
        mux[SDM_EVW-1:0] = s.mask;
      end
      default: begin
        mux = SDM_REG_RST;
      end
    endcase
  end

  // link watchdog and fault conditions
  assign cmd      = chin | s.switch_enable_bits;
  assign wd_exp   = (s.wd == WD_LAST);
  assign link_bad = wd_exp | err | ~sw_ok;
  assign clr_link = wr_hit & (ridx == SDM_CLEAR_OFF) & wdata_i[SDM_LINK_BIT];

  assign ev_in[SDM_EV_LINK] = link_bad & ~s.link_fault;
  assign ev_in[SDM_EV_OPEN] = |(~cmd & lo & ~s.open_warn);
  assign ev_in[SDM_EV_OC]   = |(cmd & ocq & ~s.oc_rep);

  always_comb begin
    next_s = s;
    next_s.s1 = {chain_pos_i, logic_side_supply_i, switch_side_supply_i,
                 link_err_i, link_beat_i, over_current_i, load_open_i,
                 channel_input_i};
    next_s.s2 = s.s1;
    next_s.beat_d = beat;
    if (beat & ~s.beat_d) begin
      next_s.wd = '0;
    end else if (!wd_exp) begin
      next_s.wd = s.wd + WDW'(1);
    end
    if (link_bad) begin
      next_s.link_fault = 1'b1;
    end else if (clr_link) begin
      next_s.link_fault = 1'b0;
    end
    // outputs off on fault, lost logic supply or over-current
    next_s.drive = cmd & ~ocq
                 & {NUM_CH{~s.link_fault & ~link_bad & lg_ok}};
    next_s.open_warn = ~cmd & lo;
    next_s.oc_rep = s.oc_rep | (cmd & ocq);
    next_s.ev = s.ev | ev_in;
    if (wr_hit) begin
      case (ridx)
        SDM_STATE_OFF: begin
          next_s.switch_enable_bits = wdata_i[NUM_CH-1:0];
        end
        SDM_CLEAR_OFF: begin
          next_s.oc_rep = (s.oc_rep & ~wdata_i[NUM_CH-1:0]) | (cmd & ocq);
        end
        SDM_IRQ_STS_OFF: begin
          next_s.ev = (s.ev & ~wdata_i[SDM_EVW-1:0]) | ev_in;
        end
        SDM_IRQ_MASK_OFF: begin
          next_s.mask = wdata_i[SDM_EVW-1:0];
        end
        default: begin
          next_s.mask = s.mask;
        end
      endcase
    end
    next_s.rdata = rd_hit ? mux : SDM_REG_RST;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o                  = s.rdata;
  assign switch_drive_o           = s.drive;
  assign state_indicator_pin_o    = '0;
  assign state_indicator_pin_oe_o = s.drive & {NUM_CH{HAS_LED_PIN}};
  assign open_load_pin_o          = 1'b0;
  assign open_load_pin_oe_o       = HAS_OPEN_PIN & (|s.open_warn);
  assign irq_o                    = |(s.ev & s.mask);

  // checks
  sdm_state_s past_s;
  logic       past_bad;
  logic       past_clr;
  logic       past_lg;
  logic       past_rdtop;
  logic [NUM_CH-1:0] past_offlo;
  logic [NUM_CH-1:0] past_oc;
  logic [NUM_CH-1:0] past_cmd;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      past_s     <= '0;
      past_bad   <= 1'b0;
      past_clr   <= 1'b0;
      past_lg    <= 1'b0;
      past_rdtop <= 1'b0;
      past_offlo <= '0;
      past_oc    <= '0;
      past_cmd   <= '0;
    end else begin
      past_s     <= s;
      past_bad   <= link_bad;
      past_clr   <= clr_link;
      past_lg    <= lg_ok;
      past_rdtop <= rd_hit & (ridx == SDM_TOP_REG_OFF);
      past_offlo <= ~cmd & lo;
      past_oc    <= ocq;
      past_cmd   <= cmd;
    end
  end

  open_when_on_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (s.open_warn & s.drive) == '0)
    else $error("open-load warning while channel driven");

  open_set_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (~cmd & lo) != '0 |=> s.open_warn == past_offlo && open_load_pin_oe_o == HAS_OPEN_PIN)
    else $error("open-load warning not raised");

  open_on_clear_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    past_cmd != '0 |-> (s.open_warn & past_cmd) == '0)
    else $error("open-load warning while commanded on");

  led_state_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    HAS_LED_PIN |-> state_indicator_pin_oe_o == switch_drive_o && state_indicator_pin_o == '0)
    else $error("indicator differs from switch state");

  fault_off_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    link_bad |=> s.drive == '0 ##1 s.drive == '0)
    else $error("outputs not disabled on link fault");

  fault_hold_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    s.link_fault && !(clr_link && !link_bad) |=> s.link_fault && s.drive == '0)
    else $error("link fault released without clear");

  supply_loss_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    !sw_ok |=> s.link_fault)
    else $error("switch supply loss missed");

  logic_loss_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    !lg_ok |=> switch_drive_o == '0)
    else $error("outputs on without logic supply");

  oc_led_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    ocq != '0 |=> (state_indicator_pin_oe_o & past_oc) == '0)
    else $error("indicator on during over-current");

  wdog_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    wd_exp && !(beat && !s.beat_d) |=> s.link_fault ##1 s.link_fault)
    else $error("watchdog expiry not reported");

  top_read_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    past_rdtop |-> rdata_o[SDM_LINK_BIT] == past_s.link_fault)
    else $error("link fault not read at bit 7");

  clear_ok_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    past_s.link_fault && !s.link_fault |-> past_clr && !past_bad)
    else $error("link fault cleared while present");

  fault_clear_c: cover property (
    @(posedge clock_i) disable iff (!rstn_i)
    s.link_fault ##1 clr_link && !link_bad ##1 !s.link_fault);

  open_load_c: cover property (
    @(posedge clock_i) disable iff (!rstn_i)
    $rose(open_load_pin_oe_o));

  oc_recover_c: cover property (
    @(posedge clock_i) disable iff (!rstn_i)
    (ocq != '0) ##1 (ocq == '0) ##1 $rose(|state_indicator_pin_oe_o));

  wdog_expire_c: cover property (
    @(posedge clock_i) disable iff (!rstn_i)
    wd_exp && !s.link_fault ##1 s.link_fault);

  chain_miss_c: cover property (
    @(posedge clock_i) disable iff (!rstn_i)
    wr_i && !sel);
endmodule

/* hw/sdm_pkg.sv */
// constants of the switch monitor: offsets, fields, reset values
package sdm_pkg;
  localparam int unsigned SDM_DW    = 8;
  localparam int unsigned SDM_AW    = 8;
  localparam int unsigned SDM_RW    = 3;
  localparam int unsigned SDM_CHW   = 5;
  localparam int unsigned SDM_MAXCH = 4;
  localparam int unsigned SDM_EVW   = 3;

  localparam logic [2:0] SDM_TOP_REG_OFF  = 3'h0;
  localparam logic [2:0] SDM_CHAN_A_OFF   = 3'h1;
  localparam logic [2:0] SDM_CHAN_B_OFF   = 3'h2;
  localparam logic [2:0] SDM_STATE_OFF    = 3'h3;
  localparam logic [2:0] SDM_CLEAR_OFF    = 3'h4;
  localparam logic [2:0] SDM_IRQ_STS_OFF  = 3'h5;
  localparam logic [2:0] SDM_IRQ_MASK_OFF = 3'h6;

  localparam int unsigned SDM_LINK_BIT  = 7;
  localparam int unsigned SDM_OW_BIT    = 0;
  localparam int unsigned SDM_OC_BIT    = 3;
  localparam int unsigned SDM_CH_STRIDE = 4;
  localparam int unsigned SDM_STATE_LSB = 4;

  localparam int unsigned SDM_EV_LINK = 0;
  localparam int unsigned SDM_EV_OPEN = 1;
  localparam int unsigned SDM_EV_OC   = 2;

  localparam logic [7:0] SDM_REG_RST  = 8'h00;
  localparam logic [2:0] SDM_MASK_RST = 3'h0;
  localparam int unsigned SDM_WDOG_CYC_DEF = 250;
endpackage

/* testbench/sdm_host_model.sv */
// host bus master model driving the register port
`timescale 1ns/1ps
module sdm_host_model
  import sdm_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic [sdm_pkg::SDM_DW-1:0] rdata_i,
  output logic      [sdm_pkg::SDM_AW-1:0] addr_o,
  output logic      [sdm_pkg::SDM_DW-1:0] wdata_o,
  output logic                            wr_o,
  output logic                            rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // one-cycle write strobe, chain position in top bits
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= v;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  // data stands in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1;
    v = rdata_i;
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench of the switch monitor
`timescale 1ns/1ps
module tb;
  import sdm_pkg::*;
  localparam logic [4:0] POS = 5'h03;
  typedef struct packed {
    logic [3:0] cin;
    logic [3:0] ld;
    logic [3:0] drv;
    logic       opn;
    logic [7:0] rg1;
  } sdm_row_s;
  sdm_row_s   rows [5] = '{'{4'h1, 4'h0, 4'h1, 1'b0, 8'h00},
                          '{4'h0, 4'h1, 4'h0, 1'b1, 8'h01},
                          '{4'h1, 4'h1, 4'h1, 1'b0, 8'h00},
                          '{4'h0, 4'h2, 4'h0, 1'b1, 8'h10},
                          '{4'h2, 4'h3, 4'h2, 1'b1, 8'h01}};
  logic       clock_i = 1'b0;
  logic       rstn_i  = 1'b0;
  logic       beat    = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic       wr, rd, err, sup2, sup1, beat_on, opn, opn_oe, irq;
  logic [3:0] ch_in, ld, oc, drv, led, led_oe;
  int         mismatches = 0;
  int         checked    = 0;
  int         cycles     = 0;

  always #20 clock_i = ~clock_i;

  sdm_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                       .wr_o(wr), .rd_o(rd));

  sdm_switch_monitor #(.NUM_CH(4), .WDOG_CYC(8)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .chain_pos_i(POS), .channel_input_i(ch_in),
    .load_open_i(ld), .over_current_i(oc), .link_beat_i(beat), .link_err_i(err),
    .switch_side_supply_i(sup2), .logic_side_supply_i(sup1), .switch_drive_o(drv),
    .state_indicator_pin_o(led), .state_indicator_pin_oe_o(led_oe),
    .open_load_pin_o(opn), .open_load_pin_oe_o(opn_oe), .irq_o(irq));

  always @(posedge clock_i) begin
    if (beat_on) begin
      beat <= ~beat;
    end
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.rd_reg({POS, idx}, v);
    chk(nm, v, exp);
  endtask
  task automatic wrr(input logic [2:0] idx, input logic [7:0] v);
    host.wr_reg({POS, idx}, v);
  endtask
  task automatic settle;
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {ch_in, ld, oc, err} = '0;
    {sup2, sup1, beat_on} = 3'b111;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    rdc("top", 3'h0, 8'h00);
    foreach (rows[i]) begin
      @(posedge clock_i);
      ch_in <= rows[i].cin;
      ld    <= rows[i].ld;
      settle();
      chk("drive", {4'h0, drv}, {4'h0, rows[i].drv});
      chk("indicator", {4'h0, led_oe}, {4'h0, rows[i].drv});
      chk("open pin", {7'h0, opn_oe}, {7'h0, rows[i].opn});
      chk("indicator low", {4'h0, led}, 8'h00);
      chk("open pin low", {7'h0, opn}, 8'h00);
      rdc("channel_register_a a", 3'h1, rows[i].rg1);
    end
    @(posedge clock_i);
    {ch_in, ld, oc} <= {4'h1, 4'h0, 4'h1};
    settle();
    chk("oc drive", {4'h0, drv}, 8'h00);
    chk("oc indicator", {4'h0, led_oe}, 8'h00);
    rdc("oc state", 3'h3, 8'h00);
    rdc("oc report", 3'h1, 8'h08);
    @(posedge clock_i);
    oc <= 4'h0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("recovered", {4'h0, led_oe}, 8'h01);
    wrr(3'h4, 8'h0f);
    rdc("oc cleared", 3'h1, 8'h00);
    @(posedge clock_i);
    ch_in <= 4'h0;
    wrr(3'h3, 8'h01);
    settle();
    chk("enable drive", {4'h0, drv}, 8'h01);
    rdc("state", 3'h3, 8'h11);
    wrr(3'h3, 8'h00);
    host.wr_reg({5'h04, 3'h3}, 8'h0f);
    settle();
    chk("other pos", {4'h0, drv}, 8'h00);
    host.rd_reg({5'h04, 3'h0}, d);
    chk("other read", d, 8'h00);
    rdc("unmapped", 3'h7, 8'h00);
    @(posedge clock_i);
    {ch_in, err} <= {4'h3, 1'b1};
    settle();
    chk("fault drive", {4'h0, drv}, 8'h00);
    rdc("fault flag", 3'h0, 8'h80);
    wrr(3'h4, 8'h80);
    rdc("kept", 3'h0, 8'h80);
    @(posedge clock_i);
    err <= 1'b0;
    settle();
    chk("still off", {4'h0, drv}, 8'h00);
    wrr(3'h4, 8'h80);
    settle();
    chk("back on", {4'h0, drv}, 8'h03);
    rdc("events", 3'h5, 8'h07);
    chk("masked", {7'h0, irq}, 8'h00);
    wrr(3'h6, 8'h01);
    settle();
    chk("unmasked", {7'h0, irq}, 8'h01);
    wrr(3'h5, 8'h07);
    settle();
    chk("irq clear", {7'h0, irq}, 8'h00);
    @(posedge clock_i);
    sup2 <= 1'b0;
    settle();
    chk("sw supply", {4'h0, drv}, 8'h00);
    rdc("sw flag", 3'h0, 8'h80);
    @(posedge clock_i);
    sup2 <= 1'b1;
    settle();
    wrr(3'h4, 8'h80);
    @(posedge clock_i);
    sup1 <= 1'b0;
    settle();
    chk("lg supply", {4'h0, drv}, 8'h00);
    @(posedge clock_i);
    {sup1, beat_on} <= 2'b10;
    repeat (14) @(posedge clock_i);
    #1;
    chk("watchdog", {4'h0, drv}, 8'h00);
    beat_on <= 1'b1;
    settle();
    wrr(3'h4, 8'h80);
    settle();
    rdc("wd clear", 3'h0, 8'h00);
    chk("drive ok", {4'h0, drv}, 8'h03);
    chk("irq link", {7'h0, irq}, 8'h01);
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    settle();
    rdc("mask rst", 3'h6, 8'h00);
    rdc("top rst", 3'h0, 8'h00);
    chk("irq rst", {7'h0, irq}, 8'h00);
    tally_and_finish();
  end
endmodule
